// [hw/routing_pkg.sv]
/*
 Constants for the peripheral signal routing block: register offsets,
 field positions, reset values and field encodings.
 Assumes a 32-bit Avalon-MM slave with word-aligned registers.
*/
package routing_pkg;
   // ==========================================================
   // Register map
   localparam logic [3:0] routing0_offset = 4'h0;
   localparam logic [3:0] routing1_offset = 4'h4;
   localparam logic [7:0] routing0_reset = 8'h00;
   localparam logic [7:0] routing1_reset = 8'h00;
   // ==========================================================
   // Field positions
   localparam int twowire_lsb = 6;
   localparam int serial1_bit = 5;
   localparam int serial0_bit = 4;
   localparam int sync_serial_bit = 3;
   localparam int can_route_lsb = 0;
   localparam int cap3_bit = 7;
   localparam int cap2_bit = 6;
   localparam int trig_falling_bit = 2;
   localparam int trig_source_lsb = 0;
   localparam logic [7:0] routing1_mask = 8'hc7;
   // ==========================================================
   // Encodings
   localparam logic [1:0] twowire_port_j = 2'h0;
   localparam logic [1:0] twowire_port_s = 2'h1;
   localparam logic [1:0] twowire_port_t = 2'h2;
   localparam logic [1:0] twowire_reserved = 2'h3;
   localparam logic [2:0] can_default = 3'h0;
   localparam logic [2:0] can_direct = 3'h1;
   localparam logic [2:0] can_probe = 3'h4;
   localparam logic [2:0] can_conformance = 3'h6;
   localparam logic [1:0] trig_compare2 = 2'h0;
   localparam logic [1:0] trig_analog15 = 2'h1;
   localparam logic [1:0] trig_analog1 = 2'h2;
   localparam logic [1:0] trig_port_p4 = 2'h3;
endpackage

// [hw/signal_routing.sv]
/*
 Peripheral signal routing: two byte-wide routing registers behind an
 Avalon-MM slave steer the two-wire bus, serial channels, synchronous
 serial port, CAN interface, timer capture inputs and converter trigger.
 Assumes all peripheral signals are on core_clk; pin inputs are
 synchronised here. Pad output enables come from the peripherals.
*/
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
module signal_routing (
   input wire logic core_clk, // System clock
   input wire logic reset_n, // Asynchronous reset, active low
   input wire logic [3:0] address, // Avalon byte address
   input wire logic read, // Avalon read
   input wire logic write, // Avalon write
   input wire logic [31:0] writedata, // Avalon write data
   input wire logic [3:0] byteenable, // Avalon byte enables
   output logic [31:0] readdata, // Avalon read data
   output logic waitrequest, // Avalon wait
   input wire logic special_mode, // High in special mode
   input wire logic twowire_scl, // Two-wire clock out
   input wire logic twowire_sda, // Two-wire data out
   input wire logic serial1_transmit, // Serial 1 transmit
   input wire logic serial0_transmit, // Serial 0 transmit
   input wire logic [3:0] spi_out, // SPI miso,mosi,sck,ss outputs
   input wire logic can_ctrl_transmit, // CAN controller transmit
   input wire logic transceiver_receive_out, // Transceiver receive
   input wire logic transceiver_direct_bit, // Direct-control bit
   input wire logic can_ctrl_enable, // CAN controller enabled
   input wire logic transceiver_enable, // Transceiver enabled
   input wire logic analog_comparator_0, // Comparator 0 out
   input wire logic analog_comparator_1, // Comparator 1 out
   input wire logic compare2_out, // First timer compare 2
   input wire logic compare2_pin_disable, // Compare 2 pin disable
   input wire logic [7:0] port_t_in, // Port T pins
   input wire logic [7:0] port_s_in, // Port S pins
   input wire logic [1:0] port_j_in, // Port J pins
   input wire logic [1:0] can_pin_in, // CAN pins rx, tx
   input wire logic port_p4_in, // Port P pin 4
   input wire logic analog1_in, // Analog port pin 1
   input wire logic analog15_in, // Analog port pin 15
   output logic [7:0] port_t_out, // Port T drive
   output logic [7:0] port_s_out, // Port S drive
   output logic [1:0] port_j_out, // Port J drive
   output logic [7:0] port_t_sel, // Port T peripheral owned
   output logic [7:0] port_s_sel, // Port S peripheral owned
   output logic [1:0] port_j_sel, // Port J peripheral owned
   output logic [1:0] can_pin_out, // CAN pin drive tx, rx
   output logic [1:0] can_pin_sel, // CAN pins owned
   output logic transceiver_transmit_in, // Transceiver transmit
   output logic can_ctrl_receive, // CAN controller receive
   output logic twowire_scl_in, // Two-wire clock in
   output logic twowire_sda_in, // Two-wire data in
   output logic serial1_receive, // Serial 1 receive
   output logic serial0_receive, // Serial 0 receive
   output logic [3:0] spi_in, // SPI miso,mosi,sck,ss inputs
   output logic timer1_cap2, // Second timer capture 2
   output logic timer1_cap3, // Second timer capture 3
   output logic conv_trigger, // Trigger, rising-edge active
   output logic compare2_pin_active, // Compare 2 drives its pin
   output logic [7:0] routing0_out, // Routing register 0
   output logic [7:0] routing1_out // Routing register 1
);
   // ==========================================================
   // Pin synchronisers
   logic [22:0] pin_meta;
   logic [22:0] pin_sync;
   wire [22:0] pin_raw = {port_t_in, port_s_in, port_j_in, can_pin_in,
      port_p4_in, analog1_in, analog15_in};
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
      end
   end
   wire [7:0] pt = pin_sync[22:15];
   wire [7:0] ps = pin_sync[14:7];
   wire [1:0] pj = pin_sync[6:5];
   wire [1:0] pcan = pin_sync[4:3];
   wire pp4 = pin_sync[2];
   wire pad1 = pin_sync[1];
   wire pad15 = pin_sync[0];

   // ==========================================================
   // Register slave
   logic [7:0] module_routing_0;
   logic [7:0] module_routing_1;
   logic routing0_locked;
   logic read_done;
   wire sel0 = address == routing_pkg::routing0_offset;
   wire sel1 = address == routing_pkg::routing1_offset;
   wire wr_lane = write && byteenable[0];
   wire wr0_ok = wr_lane && sel0 && (special_mode || !routing0_locked);
   wire wr1_ok = wr_lane && sel1;
   wire [7:0] read_mux = sel0 ? module_routing_0 :
      sel1 ? (module_routing_1 & routing_pkg::routing1_mask) : 8'h00;
   // Reads wait one cycle so data come from a flop.
   assign waitrequest = read && !read_done;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         module_routing_0 <= routing_pkg::routing0_reset;
         module_routing_1 <= routing_pkg::routing1_reset;
         routing0_locked <= 1'b0;
         readdata <= 32'h0000_0000;
         read_done <= 1'b0;
      end else begin
         if (wr0_ok) begin
            module_routing_0 <= writedata[7:0];
         end
         if (wr_lane && sel0 && !special_mode) begin
            routing0_locked <= 1'b1;
         end
         if (wr1_ok) begin
            module_routing_1 <= writedata[7:0] & routing_pkg::routing1_mask;
         end
         read_done <= read && !read_done;
         if (read && !read_done) begin
            readdata <= {24'h00_0000, read_mux};
         end
      end
   end
   assign routing0_out = module_routing_0;
   assign routing1_out = module_routing_1;

   // ==========================================================
   // Field decode
   wire [1:0] twowire_pin_select = module_routing_0[routing_pkg::twowire_lsb +: 2];
   wire serial1_pin_select = module_routing_0[routing_pkg::serial1_bit];
   wire serial0_pin_select = module_routing_0[routing_pkg::serial0_bit];
   wire sync_serial_pin_select = module_routing_0[routing_pkg::sync_serial_bit];
   wire [2:0] can_interface_route = module_routing_0[routing_pkg::can_route_lsb +: 3];
   wire timer1_cap3_source = module_routing_1[routing_pkg::cap3_bit];
   wire timer1_cap2_source = module_routing_1[routing_pkg::cap2_bit];
   wire conv_trigger_falling = module_routing_1[routing_pkg::trig_falling_bit];
   wire [1:0] conv_trigger_source = module_routing_1[routing_pkg::trig_source_lsb +: 2];

   wire tw_t = twowire_pin_select == routing_pkg::twowire_port_t;
   wire tw_s = twowire_pin_select == routing_pkg::twowire_port_s;
   wire tw_j = twowire_pin_select == routing_pkg::twowire_port_j;
   wire s1_t = serial1_pin_select;
   wire s1_s = !serial1_pin_select;
   wire s0_s = serial0_pin_select;
   wire s0_j = !serial0_pin_select;
   wire sp_t = sync_serial_pin_select;
   wire sp_s = !sync_serial_pin_select;

   // Lower pin list wins where two functions collide on a pin.
   always_comb begin
      port_t_sel = {{4{sp_t}}, 2'b00, {2{tw_t | s1_t}}};
      port_s_sel = {2'b00, {2{s1_s}}, {2{sp_s}}, {2{tw_s | s0_s | sp_s}}};
      port_j_sel = {2{tw_j | s0_j}};
      // The synchronous serial outputs are packed ss, sck, mosi, miso, which is pin order.
      port_t_out = {spi_out, 4'h0};
      port_t_out[1:0] = tw_t ? {twowire_scl, twowire_sda} :
         s1_t ? {serial1_transmit, 1'b0} : 2'b00;
      port_s_out = {2'b00, serial1_transmit, 1'b0, 4'h0};
      port_s_out[3:2] = sp_s ? spi_out[3:2] : 2'b00;
      port_s_out[1:0] = tw_s ? {twowire_scl, twowire_sda} :
         s0_s ? {serial0_transmit, 1'b0} : sp_s ? spi_out[1:0] : 2'b00;
      port_j_out = tw_j ? {twowire_scl, twowire_sda} :
         s0_j ? {serial0_transmit, 1'b0} : 2'b00;
   end
   assign twowire_scl_in = tw_t ? pt[1] : tw_s ? ps[1] : tw_j ? pj[1] : 1'b1;
   assign twowire_sda_in = tw_t ? pt[0] : tw_s ? ps[0] : tw_j ? pj[0] : 1'b1;
   assign serial1_receive = s1_t ? pt[0] : ps[4];
   assign serial0_receive = s0_s ? ps[0] : pj[0];
   // Input order: ss, sck, mosi, miso.
   assign spi_in = sp_t ? pt[7:4] : {ps[3], ps[2], ps[1], ps[0]};

   // ==========================================================
   // CAN interface
   wire can_open = can_interface_route == routing_pkg::can_conformance;
   wire can_dir = can_interface_route == routing_pkg::can_direct;
   wire can_prb = can_interface_route == routing_pkg::can_probe;
   assign transceiver_transmit_in = can_dir ? transceiver_direct_bit :
      can_open ? pcan[0] : can_ctrl_transmit;
   assign can_ctrl_receive = can_open ? pcan[1] : transceiver_receive_out;
   // Pin 1 carries controller transmit, pin 0 transceiver receive.
   assign can_pin_sel = {(can_prb | can_open) & can_ctrl_enable,
      (can_prb | can_open) & transceiver_enable};
   assign can_pin_out = {can_pin_sel[1] & can_ctrl_transmit,
      can_pin_sel[0] & transceiver_receive_out};

   // ==========================================================
   // Timer and converter trigger
   assign timer1_cap3 = timer1_cap3_source ? analog_comparator_1 : pt[3];
   assign timer1_cap2 = timer1_cap2_source ? analog_comparator_0 : pt[2];
   wire trig_raw = conv_trigger_source == routing_pkg::trig_port_p4 ? pp4 :
      conv_trigger_source == routing_pkg::trig_analog1 ? pad1 :
      conv_trigger_source == routing_pkg::trig_analog15 ? pad15 : compare2_out;
   assign conv_trigger = trig_raw ^ conv_trigger_falling;
   // Trigger selection never steals the compare pin.
   assign compare2_pin_active = !compare2_pin_disable;

   // ==========================================================
   // Checks
   a_lock_holds: assert property (@(posedge core_clk) disable iff (!reset_n)
      routing0_locked && !special_mode |=> $stable(module_routing_0))
      else $error("routing 0 changed while locked");
   a_first_write: assert property (@(posedge core_clk) disable iff (!reset_n)
      wr_lane && sel0 && !routing0_locked |=> module_routing_0 == $past(writedata[7:0]))
      else $error("first write to routing 0 lost");
   a_reserved_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
      (module_routing_1 & ~routing_pkg::routing1_mask) == 8'h00)
      else $error("reserved bits set");
   sequence s_read_req;
      read && !waitrequest ##0 sel1;
   endsequence
   a_read_timing: assert property (@(posedge core_clk) disable iff (!reset_n)
      $rose(read) |-> waitrequest ##1 !waitrequest)
      else $error("read answer not one cycle late");
   a_read_data: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_read_req |-> readdata[7:0] == $past(read_mux) && readdata[31:8] == 24'h00_0000)
      else $error("read data wrong");
   a_can_direct: assert property (@(posedge core_clk) disable iff (!reset_n)
      can_dir |-> transceiver_transmit_in == transceiver_direct_bit && can_pin_sel == 2'b00)
      else $error("direct control route wrong");
   a_can_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
      !can_ctrl_enable |-> !can_pin_sel[1] && !can_pin_out[1])
      else $error("controller pin driven while disabled");
   a_cap3_src: assert property (@(posedge core_clk) disable iff (!reset_n)
      !timer1_cap3_source |-> timer1_cap3 == pin_sync[18])
      else $error("capture 3 source wrong");
   a_trig_pol: assert property (@(posedge core_clk) disable iff (!reset_n)
      conv_trigger_source == routing_pkg::trig_compare2 |->
      conv_trigger == (compare2_out ^ conv_trigger_falling))
      else $error("trigger polarity wrong");

   // ==========================================================
   // Register checks
   // The lock must survive every cycle until reset, or a stray write could
   // move the bus pins under running software.

   a_reg1_write: assert property (@(posedge core_clk) disable iff (!reset_n)
      wr1_ok |=> module_routing_1 == ($past(writedata[7:0]) & routing_pkg::routing1_mask))
      else $error("routing 1 write lost");

   a_lock_set: assert property (@(posedge core_clk) disable iff (!reset_n)
      wr_lane && sel0 && !special_mode |=> routing0_locked)
      else $error("normal mode write did not lock");

   a_lock_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
      routing0_locked |=> routing0_locked)
      else $error("lock cleared without reset");

   a_special_write: assert property (@(posedge core_clk) disable iff (!reset_n)
      wr_lane && sel0 && special_mode |=> module_routing_0 == $past(writedata[7:0]))
      else $error("special mode write lost");

   a_write_nowait: assert property (@(posedge core_clk) disable iff (!reset_n)
      write |-> !waitrequest)
      else $error("write stalled");

   // ==========================================================
   // Routing checks
   // Pin drive is only compared where the pin is owned, since the pad
   // ignores the drive value of a pin that the port keeps for itself.

   a_twowire_t: assert property (@(posedge core_clk) disable iff (!reset_n)
      tw_t |-> port_t_sel[1:0] == 2'b11 && port_t_out[1:0] == {twowire_scl, twowire_sda})
      else $error("two-wire port T route wrong");

   a_twowire_j: assert property (@(posedge core_clk) disable iff (!reset_n)
      tw_j |-> port_j_sel == 2'b11 && port_j_out == {twowire_scl, twowire_sda})
      else $error("two-wire port J route wrong");

   a_twowire_rsvd: assert property (@(posedge core_clk) disable iff (!reset_n)
      twowire_pin_select == routing_pkg::twowire_reserved |-> twowire_scl_in && twowire_sda_in)
      else $error("reserved two-wire route not idle");

   a_serial1_s: assert property (@(posedge core_clk) disable iff (!reset_n)
      s1_s |-> port_s_sel[5:4] == 2'b11 && port_s_out[5] == serial1_transmit)
      else $error("serial 1 port S route wrong");

   a_serial1_t: assert property (@(posedge core_clk) disable iff (!reset_n)
      s1_t && !tw_t |-> port_t_sel[1:0] == 2'b11 && port_t_out[1] == serial1_transmit)
      else $error("serial 1 port T route wrong");

   a_serial0_j: assert property (@(posedge core_clk) disable iff (!reset_n)
      s0_j && !tw_j |-> port_j_out[1] == serial0_transmit && serial0_receive == pj[0])
      else $error("serial 0 port J route wrong");

   a_serial0_s: assert property (@(posedge core_clk) disable iff (!reset_n)
      s0_s && !tw_s |-> port_s_out[1] == serial0_transmit && serial0_receive == ps[0])
      else $error("serial 0 port S route wrong");

   a_spi_t: assert property (@(posedge core_clk) disable iff (!reset_n)
      sp_t |-> port_t_sel[7:4] == 4'hf && port_t_out[7:4] == spi_out && spi_in == pt[7:4])
      else $error("serial port T route wrong");

   a_spi_s: assert property (@(posedge core_clk) disable iff (!reset_n)
      sp_s |-> port_s_sel[3:2] == 2'b11 && port_s_out[3:2] == spi_out[3:2] && spi_in == ps[3:0])
      else $error("serial port S route wrong");

   // ==========================================================
   // CAN, timer capture and trigger checks

   a_can_default: assert property (@(posedge core_clk) disable iff (!reset_n)
      can_interface_route == routing_pkg::can_default |->
      transceiver_transmit_in == can_ctrl_transmit &&
      can_ctrl_receive == transceiver_receive_out && can_pin_sel == 2'b00)
      else $error("default CAN route wrong");

   a_can_probe: assert property (@(posedge core_clk) disable iff (!reset_n)
      can_prb |-> transceiver_transmit_in == can_ctrl_transmit &&
      can_ctrl_receive == transceiver_receive_out)
      else $error("probe CAN route wrong");

   a_can_open: assert property (@(posedge core_clk) disable iff (!reset_n)
      can_open |-> transceiver_transmit_in == pcan[0] && can_ctrl_receive == pcan[1])
      else $error("opened CAN route wrong");

   a_phy_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
      !transceiver_enable |-> !can_pin_sel[0] && !can_pin_out[0])
      else $error("transceiver pin driven while disabled");

   a_cap3_comp: assert property (@(posedge core_clk) disable iff (!reset_n)
      timer1_cap3_source |-> timer1_cap3 == analog_comparator_1)
      else $error("capture 3 comparator route wrong");

   a_cap2_src: assert property (@(posedge core_clk) disable iff (!reset_n)
      timer1_cap2_source |-> timer1_cap2 == analog_comparator_0)
      else $error("capture 2 comparator route wrong");

   a_trig_port: assert property (@(posedge core_clk) disable iff (!reset_n)
      conv_trigger_source == routing_pkg::trig_port_p4 |-> conv_trigger == (pp4 ^ conv_trigger_falling))
      else $error("port trigger route wrong");

   a_trig_falling: assert property (@(posedge core_clk) disable iff (!reset_n)
      conv_trigger_falling && conv_trigger_source == routing_pkg::trig_analog15 |->
      conv_trigger == !pad15)
      else $error("falling trigger not inverted");

   a_compare_pin: assert property (@(posedge core_clk) disable iff (!reset_n)
      !compare2_pin_disable |-> compare2_pin_active)
      else $error("compare pin action stopped");
endmodule

// [test/periph_model.sv]
/*
 Pin-side model for the signal routing bench: external levels on the
 shared port pins, all derived from one pattern byte.
 Assumes the bench changes the pattern just after a rising clock edge.
*/
`timescale 1ns/1ps
module periph_model (
   input wire logic [7:0] pat, // Pattern chosen by the bench
   output logic [7:0] port_t_in, // Port T pin levels
   output logic [7:0] port_s_in, // Port S pin levels
   output logic [1:0] port_j_in, // Port J pin levels
   output logic [1:0] can_pin_in, // CAN pin levels rx, tx
   output logic port_p4_in, // Port P pin 4 level
   output logic analog1_in, // Analog pin 1 level
   output logic analog15_in // Analog pin 15 level
);
   // ==========================================================
   // Pin levels
   // Port S carries the inverse of port T, so routings of one signal to the
   // same pin number on port T and port S never read the same level by accident.
   assign port_t_in = pat;
   assign port_s_in = ~pat;
   assign port_j_in = pat[7:6];
   assign can_pin_in = pat[5:4];
   assign port_p4_in = pat[6];
   assign analog1_in = pat[7];
   assign analog15_in = pat[1];
endmodule

// [test/tb.sv]
/*
 Self-checking bench for the signal routing block: register access over
 Avalon-MM, pin and peripheral routing, write-once locking.
 Assumes the pin model and the routing package are compiled first.
*/
`timescale 1ns/1ps
module tb;
   localparam logic [3:0] off0 = routing_pkg::routing0_offset;
   localparam logic [3:0] off1 = routing_pkg::routing1_offset;
   logic core_clk = 1'b0, reset_n = 1'b0, read = 1'b0, write = 1'b0, special_mode = 1'b1;
   logic can_ctrl_enable = 1'b1, transceiver_enable = 1'b1, compare2_pin_disable = 1'b0;
   logic [3:0] address = 4'h0, byteenable = 4'h1, spi_in;
   logic [31:0] writedata = 32'h0, readdata;
   logic [7:0] pat = 8'h96, port_t_in, port_s_in, port_t_out, port_s_out, port_t_sel;
   logic [7:0] port_s_sel, routing0_out, routing1_out;
   logic [1:0] port_j_in, can_pin_in, port_j_out, port_j_sel, can_pin_out, can_pin_sel;
   logic waitrequest, port_p4_in, analog1_in, analog15_in, transceiver_transmit_in;
   logic can_ctrl_receive, twowire_scl_in, twowire_sda_in, serial1_receive, serial0_receive;
   logic timer1_cap2, timer1_cap3, conv_trigger, compare2_pin_active;
   int n_errors = 0;
   int tests_run = 0;
   always #5 core_clk = ~core_clk;
   periph_model periph_model_inst (.pat, .port_t_in, .port_s_in, .port_j_in, .can_pin_in,
      .port_p4_in, .analog1_in, .analog15_in);
   signal_routing signal_routing_inst (.core_clk, .reset_n, .address, .read, .write,
      .writedata, .byteenable, .readdata, .waitrequest, .special_mode, .twowire_scl(pat[0]),
      .twowire_sda(pat[1]), .serial1_transmit(pat[2]), .serial0_transmit(pat[3]),
      .spi_out(pat[7:4]), .can_ctrl_transmit(pat[0]), .transceiver_receive_out(pat[1]),
      .transceiver_direct_bit(pat[2]), .can_ctrl_enable, .transceiver_enable,
      .analog_comparator_0(pat[3]), .analog_comparator_1(pat[4]), .compare2_out(pat[5]),
      .compare2_pin_disable, .port_t_in, .port_s_in, .port_j_in, .can_pin_in, .port_p4_in,
      .analog1_in, .analog15_in, .port_t_out, .port_s_out, .port_j_out, .port_t_sel,
      .port_s_sel, .port_j_sel, .can_pin_out, .can_pin_sel, .transceiver_transmit_in,
      .can_ctrl_receive, .twowire_scl_in, .twowire_sda_in, .serial1_receive,
      .serial0_receive, .spi_in, .timer1_cap2, .timer1_cap3, .conv_trigger,
      .compare2_pin_active, .routing0_out, .routing1_out);
   // ==========================================================
   // Access and checking tasks
   task automatic give_verdict;
      $display("mismatches %0d, comparisons %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      address <= a;
      writedata <= {24'h0, d};
      write <= 1'b1;
      do @(posedge core_clk); while (waitrequest);
      write <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      logic [31:0] got;
      @(posedge core_clk);
      address <= a;
      read <= 1'b1;
      do @(posedge core_clk); while (waitrequest);
      got = readdata;
      read <= 1'b0;
      chk(got, {24'h0, exp});
   endtask
   // Pins pass a two-flop synchroniser, so four edges leave every path settled.
   task automatic put(input logic [7:0] p, input logic d);
      @(posedge core_clk);
      pat <= p;
      compare2_pin_disable <= d;
      repeat (4) @(posedge core_clk);
   endtask
   task automatic verify(input logic [7:0] r0, r1, input logic ce, te);
      logic [7:0] p, q;
      logic [3:0] t;
      logic [1:0] e2, tx;
      @(posedge core_clk);
      can_ctrl_enable <= ce;
      transceiver_enable <= te;
      wr(off0, r0);
      wr(off1, r1);
      rd_chk(off0, r0);
      rd_chk(off1, r1 & routing_pkg::routing1_mask);
      for (int i = 0; i < 2; i++) begin
         p = i ? 8'h69 : 8'h96;
         q = ~p;
         t = {p[6], p[7], p[1], p[5]};
         put(p, i[0]);
         e2 = r0[7] ? (r0[6] ? 2'h3 : p[1:0]) : (r0[6] ? q[1:0] : p[7:6]);
         chk({twowire_scl_in, twowire_sda_in}, e2);
         chk(serial1_receive, r0[5] ? p[0] : q[4]);
         if (r0[4] ? (r0[7:6] != 2'h1 && r0[3]) : (r0[7:6] != 2'h0))
            chk(serial0_receive, r0[4] ? q[0] : p[6]);
         if (r0[3] || (r0[7:6] != 2'h1 && !r0[4]))
            chk(spi_in, r0[3] ? p[7:4] : q[3:0]);
         case (r0[2:0])
            3'h1: chk(transceiver_transmit_in, p[2]);
            3'h6: chk({can_ctrl_receive, transceiver_transmit_in}, p[5:4]);
            default: chk({can_ctrl_receive, transceiver_transmit_in}, p[1:0]);
         endcase
         chk(can_pin_sel, r0[2] ? {ce, te} : 2'h0);
         if (r0[2]) chk(can_pin_out & can_pin_sel, {p[0], p[1]} & can_pin_sel);
         chk(timer1_cap3, r1[7] ? p[4] : p[3]);
         chk(timer1_cap2, r1[6] ? p[3] : p[2]);
         chk(conv_trigger, t[r1[1:0]] ^ r1[2]);
         chk(compare2_pin_active, !compare2_pin_disable);
         chk({routing0_out, routing1_out}, {r0, r1 & routing_pkg::routing1_mask});
         tx = (r0[7:6] == 2'h2) ? {p[0], p[1]} : {p[2], 1'b0};
         chk(port_t_sel, {{4{r0[3]}}, 2'b00, {2{r0[7:6] == 2'h2 || r0[5]}}});
         chk(port_t_out & port_t_sel, {p[7:4], 2'b00, tx} & port_t_sel);
         tx = (r0[7:6] == 2'h0) ? {p[0], p[1]} : {p[3], 1'b0};
         chk(port_j_sel, {2{r0[7:6] == 2'h0 || !r0[4]}});
         chk(port_j_out & port_j_sel, tx & port_j_sel);
         chk(port_s_sel[5:2], {{2{!r0[5]}}, {2{!r0[3]}}});
         chk(port_s_out[5:2] & port_s_sel[5:2], {p[2], 1'b0, p[7:6]} & port_s_sel[5:2]);
      end
   endtask
   // ==========================================================
   // Test sequence
   initial begin
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      rd_chk(off0, routing_pkg::routing0_reset);
      rd_chk(off1, routing_pkg::routing1_reset);
      wr(4'h8, 8'h5a);
      rd_chk(4'h8, 8'h00);
      verify(8'h80, 8'h00, 1'b1, 1'b1);
      verify(8'h79, 8'hc5, 1'b1, 1'b1);
      verify(8'h0c, 8'h42, 1'b1, 1'b1);
      verify(8'hc6, 8'h87, 1'b1, 1'b0);
      verify(8'h98, 8'h04, 1'b1, 1'b1);
      verify(8'h44, 8'h03, 1'b0, 1'b1);
      @(posedge core_clk);
      special_mode <= 1'b0;
      wr(off0, 8'h10);
      rd_chk(off0, 8'h10);
      wr(off0, 8'h20);
      rd_chk(off0, 8'h10);
      wr(off1, 8'h01);
      rd_chk(off1, 8'h01);
      @(posedge core_clk);
      special_mode <= 1'b1;
      wr(off0, 8'h20);
      rd_chk(off0, 8'h20);
      @(posedge core_clk);
      reset_n <= 1'b0;
      special_mode <= 1'b0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      rd_chk(off0, 8'h00);
      wr(off0, 8'h30);
      rd_chk(off0, 8'h30);
      give_verdict();
   end
   initial begin
      #100000;
      n_errors++;
      give_verdict();
   end
endmodule
